// File: hw/csc_core.sv
// Function
// - Overflow flags track each accumulator pass
// - Saturation flags sticky, software clear only
// - Bit 11 reads OR of overflows
// - Bit 10 ORs saturations; clear clears both
// - Loop active bits mirror loop unit
// - Digit carry from nibble or byte
// - Carry from top bit; inverted borrow on subtract
// - Negative flag follows result sign
// - Signed overflow when sign flips wrongly
// - Zero flag set by zero result, cleared by nonzero result
// - Four-bit priority; level seven blocks users
// - Low three priority bits write-locked while nesting disabled
// - Multiply sign and integer mode controls
// - Early exit bit pulses, reads zero
// - Loop depth reported read-only
// - Saturation enables, data write enabled reset
// - Clip width selects super or normal
// - Top priority bit clear-only by software
// - Program window enable control
// - Rounding mode select control
// - ALU add, sub, shift, logic, byte/word
// - Shared multiplier with listed MCU modes
module csc_core
  import csc_pkg::*;
#(
  parameter int WORD_W = 16
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // ALU request
  input  wire logic        aluGo,
  input  wire csc_aluop_t  aluOp,
  input  wire logic        aluByte,
  input  wire logic [15:0] aluA,
  input  wire logic [15:0] aluB,
  output logic      [15:0] aluResult,
  output logic             aluDone,
  // Multiplier request
  input  wire logic        mulGo,
  input  wire csc_mulmode_t mulMode,
  input  wire logic [15:0] mulA,
  input  wire logic [15:0] mulB,
  output logic      [31:0] mulProduct,
  output logic             mulDone,
  // Accumulator events
  input  wire logic        accAUpd,
  input  wire logic        accAOvf,
  input  wire logic        accASat,
  input  wire logic        accBUpd,
  input  wire logic        accBOvf,
  input  wire logic        accBSat,
  // Loop unit
  input  wire logic        doActive,
  input  wire logic        repActive,
  input  wire logic [2:0]  loopDepth,
  output logic             earlyExit,
  // Interrupt controller
  input  wire logic        nestingDisable,
  input  wire logic        priLoad,
  input  wire logic [3:0]  priIn,
  output logic      [3:0]  cpuPriority,
  output logic             userIrqOff,
  // Engine configuration
  output logic             mulUnsigned,
  output logic             mulInteger,
  output logic             accAClipEn,
  output logic             accBClipEn,
  output logic             memWrClipEn,
  output logic             superClip,
  output logic             progWindowEn,
  output logic             roundBiased
);

  if (WORD_W != 16) begin : g_chk
    $error("csc_core supports only a 16-bit word");
  end

  ////////////////////////////////////////////////////////////
  // Bus slave
  csc_bus_t    busState_ff;
  logic [31:0] datOut_ff;
  logic [15:0] statusWord;
  logic [15:0] ctlWord;
  logic [15:0] rdWord;
  wire         busReq  = cyc_i && stb_i;
  wire         selStat = adr_i == ADR_STATUS;
  wire         selCtl  = adr_i == ADR_CONTROL;
  // Writes land on the edge where ack is sampled
  wire         commit  = busReq && we_i && ack_o;
  wire         wrStatLo = commit && selStat && sel_i[0];
  wire         wrStatHi = commit && selStat && sel_i[1];
  wire         wrCtlLo  = commit && selCtl && sel_i[0];
  wire         wrCtlHi  = commit && selCtl && sel_i[1];

  // Unmapped reads return zero, still acknowledged
  assign rdWord = selStat ? statusWord :
                  selCtl  ? ctlWord : 16'h0000;
  assign ack_o  = busState_ff == BUS_ACK;
  assign dat_o  = datOut_ff;

  // One wait state, ack drops after one cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busState_ff <= BUS_IDLE;
    end else if (busState_ff == BUS_ACK) begin
      busState_ff <= BUS_IDLE;
    end else if (busReq) begin
      busState_ff <= BUS_ACK;
    end
  end

  // Read data captured as ack rises
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      datOut_ff <= 32'h00000000;
    end else if (busReq && !ack_o) begin
      datOut_ff <= {16'h0000, rdWord};
    end
  end

  ////////////////////////////////////////////////////////////
  // Accumulator status
  logic wrapA_ff;
  logic wrapB_ff;
  logic clipA_ff;
  logic clipB_ff;
  // Clearing either the flag or the combined bit clears it
  wire  clrClipA  = wrStatHi && (!dat_i[B_CA] || !dat_i[B_CAB]);
  wire  clrClipB  = wrStatHi && (!dat_i[B_CB] || !dat_i[B_CAB]);
  wire  nxt_clipA = accASat || (clipA_ff && !clrClipA);
  wire  nxt_clipB = accBSat || (clipB_ff && !clrClipB);

  // Overflow follows every pass; not writable
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wrapA_ff <= 1'b0;
      wrapB_ff <= 1'b0;
    end else begin
      if (accAUpd) wrapA_ff <= accAOvf;
      if (accBUpd) wrapB_ff <= accBOvf;
    end
  end

  // Sticky; a new event beats a clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clipA_ff <= 1'b0;
      clipB_ff <= 1'b0;
    end else begin
      clipA_ff <= nxt_clipA;
      clipB_ff <= nxt_clipB;
    end
  end

  ////////////////////////////////////////////////////////////
  // ALU datapath
  logic [15:0] res;
  logic        cOut;
  logic        ncOut;
  logic        swOut;
  logic        arith;
  wire         isSub = aluOp == OP_SUB;
  // Subtract is add of complement plus one
  wire  [15:0] opB   = isSub ? ~aluB : aluB;
  wire  [16:0] sumW  = {1'b0, aluA} + {1'b0, opB}
                       + {16'h0000, isSub};
  wire  [8:0]  sumB  = {1'b0, aluA[7:0]} + {1'b0, opB[7:0]}
                       + {8'h00, isSub};
  wire  [4:0]  sumN  = {1'b0, aluA[3:0]} + {1'b0, opB[3:0]}
                       + {4'h0, isSub};
  wire         aMsb  = aluByte ? aluA[7] : aluA[15];
  wire         bMsb  = aluByte ? opB[7] : opB[15];
  wire         rMsb  = aluByte ? res[7] : res[15];
  wire         resZero = aluByte ? res[7:0] == 8'h00
                                 : res == 16'h0000;

  // Byte ops leave the upper result byte zero
  always_comb begin
    res   = 16'h0000;
    cOut  = 1'b0;
    arith = 1'b0;
    case (aluOp)
      OP_ADD, OP_SUB: begin
        arith = 1'b1;
        res   = aluByte ? {8'h00, sumB[7:0]} : sumW[15:0];
        cOut  = aluByte ? sumB[8] : sumW[16];
      end
      OP_AND: res = aluA & aluB;
      OP_OR:  res = aluA | aluB;
      OP_XOR: res = aluA ^ aluB;
      OP_SHL: begin
        res  = {aluA[14:0], 1'b0};
        cOut = aMsb;
      end
      OP_SHR: begin
        res  = aluByte ? {9'h000, aluA[7:1]}
                       : {1'b0, aluA[15:1]};
        cOut = aluA[0];
      end
      OP_ASR: begin
        res  = aluByte ? {8'h00, aluA[7], aluA[7:1]}
                       : {aluA[15], aluA[15:1]};
        cOut = aluA[0];
      end
      default: res = 16'h0000;
    endcase
    if (aluByte) begin
      res[15:8] = 8'h00;
    end
  end

  // Digit carry out of bit 3 for bytes, bit 7 for words
  assign ncOut = aluByte ? sumN[4] : sumB[8];
  // Like signs in, different sign out
  assign swOut = arith && (aMsb == bMsb)
                 && (rMsb != aMsb);

  ////////////////////////////////////////////////////////////
  // Arithmetic flags
  logic n_ff;
  logic sw_ff;
  logic z_ff;
  logic c_ff;
  logic nc_ff;
  logic [15:0] aluRes_ff;
  logic        aluDone_ff;

  // A finishing ALU op beats a software write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      n_ff  <= 1'b0;
      sw_ff <= 1'b0;
      z_ff  <= 1'b0;
      c_ff  <= 1'b0;
    end else if (aluGo) begin
      n_ff  <= rMsb;
      sw_ff <= swOut;
      z_ff  <= resZero;
      if (arith || aluOp >= OP_SHL) c_ff <= cOut;
    end else if (wrStatLo) begin
      n_ff  <= dat_i[B_N];
      sw_ff <= dat_i[B_SW];
      z_ff  <= dat_i[B_Z];
      c_ff  <= dat_i[B_C];
    end
  end

  // Digit carry only from add and subtract
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      nc_ff <= 1'b0;
    end else if (aluGo && arith) begin
      nc_ff <= ncOut;
    end else if (wrStatHi) begin
      nc_ff <= dat_i[B_NC];
    end
  end

  // Result register and done pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aluRes_ff  <= 16'h0000;
      aluDone_ff <= 1'b0;
    end else begin
      aluDone_ff <= aluGo;
      if (aluGo) aluRes_ff <= res;
    end
  end

  assign aluResult = aluRes_ff;
  assign aluDone   = aluDone_ff;

  ////////////////////////////////////////////////////////////
  // Priority level
  logic [2:0] pri_ff;
  logic       pri3_ff;

  // Controller load wins; software locked by nesting off
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pri_ff <= 3'h0;
    end else if (priLoad) begin
      pri_ff <= priIn[2:0];
    end else if (wrStatLo && !nestingDisable) begin
      pri_ff <= dat_i[B_PRI +: 3];
    end
  end

  // Software can only clear the top bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pri3_ff <= 1'b0;
    end else if (priLoad) begin
      pri3_ff <= priIn[3];
    end else if (wrCtlLo && !dat_i[C_PRI3]) begin
      pri3_ff <= 1'b0;
    end
  end

  assign cpuPriority = {pri3_ff, pri_ff};
  assign userIrqOff  = pri3_ff || pri_ff == PRI_TOP;

  ////////////////////////////////////////////////////////////
  // Control word
  logic [15:0] ctl_ff;
  logic        exit_ff;
  wire  [15:0] ctlLane = {{8{wrCtlHi}}, {8{wrCtlLo}}};
  wire  [15:0] ctlMask = ctlLane & CTL_WMASK;

  // Only writable fields are stored
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctl_ff <= CTL_RST;
    end else begin
      ctl_ff <= (ctl_ff & ~ctlMask)
                | (dat_i[15:0] & ctlMask);
    end
  end

  // Early exit is a pulse, never stored for read
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      exit_ff <= 1'b0;
    end else begin
      exit_ff <= wrCtlHi && dat_i[C_EXIT];
    end
  end

  assign earlyExit    = exit_ff;
  assign mulUnsigned  = ctl_ff[C_UNS];
  assign mulInteger   = ctl_ff[C_IF];
  assign accAClipEn   = ctl_ff[C_CLA];
  assign accBClipEn   = ctl_ff[C_CLB];
  assign memWrClipEn  = ctl_ff[C_CLM];
  assign superClip    = ctl_ff[C_CLW];
  assign progWindowEn = ctl_ff[C_PWN];
  assign roundBiased  = ctl_ff[C_RBS];

  ////////////////////////////////////////////////////////////
  // Read views
  always_comb begin
    statusWord          = 16'h0000;
    statusWord[B_WA]    = wrapA_ff;
    statusWord[B_WB]    = wrapB_ff;
    statusWord[B_CA]    = clipA_ff;
    statusWord[B_CB]    = clipB_ff;
    statusWord[B_WAB]   = wrapA_ff || wrapB_ff;
    statusWord[B_CAB]   = clipA_ff || clipB_ff;
    statusWord[B_LP]    = doActive;
    statusWord[B_NC]    = nc_ff;
    statusWord[B_PRI +: 3] = pri_ff;
    statusWord[B_RP]    = repActive;
    statusWord[B_N]     = n_ff;
    statusWord[B_SW]    = sw_ff;
    statusWord[B_Z]     = z_ff;
    statusWord[B_C]     = c_ff;
  end

  // Exit bit reads zero; depth comes from the loop unit
  always_comb begin
    ctlWord             = ctl_ff & CTL_WMASK;
    ctlWord[C_DEP +: 3] = loopDepth;
    ctlWord[C_PRI3]     = pri3_ff;
  end

  ////////////////////////////////////////////////////////////
  // Shared 17x17 multiplier
  logic signed [16:0] mulX;
  logic signed [16:0] mulY;
  logic signed [33:0] prodFull;
  logic        [31:0] mul_ff;
  logic               mulDone_ff;
  // Extension into bit 16 selects signedness
  wire                dspSx = !ctl_ff[C_UNS];

  always_comb begin
    mulX = {1'b0, mulA};
    mulY = {1'b0, mulB};
    case (mulMode)
      MUL_SS: begin
        mulX = {mulA[15], mulA};
        mulY = {mulB[15], mulB};
      end
      MUL_UU: begin
        mulX = {1'b0, mulA};
        mulY = {1'b0, mulB};
      end
      MUL_SL5: begin
        mulX = {mulA[15], mulA};
        mulY = {12'h000, mulB[4:0]};
      end
      MUL_UL5: begin
        mulX = {1'b0, mulA};
        mulY = {12'h000, mulB[4:0]};
      end
      MUL_UXS: begin
        mulX = {1'b0, mulA};
        mulY = {mulB[15], mulB};
      end
      MUL_U8: begin
        mulX = {9'h000, mulA[7:0]};
        mulY = {9'h000, mulB[7:0]};
      end
      MUL_DSP: begin
        mulX = {dspSx && mulA[15], mulA};
        mulY = {dspSx && mulB[15], mulB};
      end
      default: begin
        mulX = 17'h00000;
        mulY = 17'h00000;
      end
    endcase
  end

  assign prodFull = mulX * mulY;

  // Fractional DSP products drop the duplicate sign bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mul_ff     <= 32'h00000000;
      mulDone_ff <= 1'b0;
    end else begin
      mulDone_ff <= mulGo;
      if (mulGo && mulMode == MUL_DSP && !ctl_ff[C_IF]) begin
        mul_ff <= {prodFull[30:0], 1'b0};
      end else if (mulGo) begin
        mul_ff <= prodFull[31:0];
      end
    end
  end

  assign mulProduct = mul_ff;
  assign mulDone    = mulDone_ff;

  ////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_req;
    busReq && !ack_o;
  endsequence

  sequence s_ackOnce;
    ack_o ##1 !ack_o;
  endsequence

  a_bus_ack_once: assert property (s_req |=> s_ackOnce)
    else $error("bus ack not a single pulse");

  a_wrap_track: assert property (
    accAUpd |=> statusWord[B_WA] == $past(accAOvf))
    else $error("accumulator A overflow not tracked");

  a_clip_sticky: assert property (
    (clipA_ff && !clrClipA) || accASat |=> clipA_ff)
    else $error("saturation flag A lost");

  a_clip_any_clear: assert property (
    wrStatHi && !dat_i[B_CAB] && !accASat && !accBSat
    |=> !statusWord[B_CAB])
    else $error("combined clip clear failed");

  a_zero_result: assert property (
    aluGo |=> z_ff == ($past(aluByte)
      ? aluResult[7:0] == 8'h00 : aluResult == 16'h0000))
    else $error("zero flag disagrees with result");

  a_sub_borrow: assert property (
    aluGo && isSub && !aluByte && aluA >= aluB |=> c_ff)
    else $error("carry not set for no-borrow subtract");

  a_pri_locked: assert property (
    nestingDisable && !priLoad |=> $stable(pri_ff))
    else $error("priority changed while locked");

  a_user_block: assert property (
    userIrqOff == (cpuPriority > 4'h6))
    else $error("user interrupt block wrong");

  a_exit_pulse: assert property (
    wrCtlHi && dat_i[C_EXIT] |=> earlyExit ##1 !earlyExit)
    else $error("early exit not a one-cycle pulse");

endmodule

// File: inc/csc_pkg.sv
package csc_pkg;
  // Register map, byte addresses on the bus
  localparam logic [3:0] ADR_STATUS  = 4'h0;
  localparam logic [3:0] ADR_CONTROL = 4'h4;

  // Status word field positions
  localparam int B_WA  = 15;
  localparam int B_WB  = 14;
  localparam int B_CA  = 13;
  localparam int B_CB  = 12;
  localparam int B_WAB = 11;
  localparam int B_CAB = 10;
  localparam int B_LP  = 9;
  localparam int B_NC  = 8;
  localparam int B_PRI = 5;
  localparam int B_RP  = 4;
  localparam int B_N   = 3;
  localparam int B_SW  = 2;
  localparam int B_Z   = 1;
  localparam int B_C   = 0;

  // Control word field positions
  localparam int C_UNS    = 12;
  localparam int C_EXIT   = 11;
  localparam int C_DEP    = 8;
  localparam int C_CLA    = 7;
  localparam int C_CLB    = 6;
  localparam int C_CLM    = 5;
  localparam int C_CLW    = 4;
  localparam int C_PRI3   = 3;
  localparam int C_PWN    = 2;
  localparam int C_RBS    = 1;
  localparam int C_IF     = 0;

  // Reset values and masks
  localparam logic [15:0] CTL_RST   = 16'h0020;
  localparam logic [15:0] CTL_WMASK = 16'h10F7;
  localparam logic [2:0]  PRI_TOP   = 3'h7;

  // ALU operations
  typedef enum logic [2:0] {
    OP_ADD = 3'h0,
    OP_SUB = 3'h1,
    OP_AND = 3'h2,
    OP_OR  = 3'h3,
    OP_XOR = 3'h4,
    OP_SHL = 3'h5,
    OP_SHR = 3'h6,
    OP_ASR = 3'h7
  } csc_aluop_t;

  // Multiplier modes
  typedef enum logic [2:0] {
    MUL_SS  = 3'h0,
    MUL_UU  = 3'h1,
    MUL_SL5 = 3'h2,
    MUL_UL5 = 3'h3,
    MUL_UXS = 3'h4,
    MUL_U8  = 3'h5,
    MUL_DSP = 3'h6
  } csc_mulmode_t;

  // Bus slave states
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } csc_bus_t;
endpackage

// File: tb/csc_core_test.sv
module csc_core_test import csc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////////////////////
  // Bench signals
  logic         clock, rst, cyc, stb, we, ack, lastExit;
  logic [3:0]   adr, sel, priIn, cpuPriority;
  logic [31:0]  wdat, datO, mulProduct, rd;
  logic         aluGo, aluByte, aluDone, mulGo, mulDone;
  csc_aluop_t   aluOp;
  csc_mulmode_t mulMode;
  logic [15:0]  aluA, aluB, aluResult, mulA, mulB, stExp, ctlExp, d;
  logic         accAUpd, accAOvf, accASat, accBUpd, accBOvf, accBSat;
  logic         doActive, repActive, earlyExit, nestingDisable, priLoad, userIrqOff;
  logic [2:0]   loopDepth;
  wire  [7:0]   cfg;
  int           fail_count, total_checks;

  ////////////////////////////////////////////////////////////////////////////
  // Device under test
  csc_core DUT (
    .clock(clock), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(datO), .ack_o(ack),
    .aluGo(aluGo), .aluOp(aluOp), .aluByte(aluByte), .aluA(aluA), .aluB(aluB),
    .aluResult(aluResult), .aluDone(aluDone),
    .mulGo(mulGo), .mulMode(mulMode), .mulA(mulA), .mulB(mulB), .mulProduct(mulProduct), .mulDone(mulDone),
    .accAUpd(accAUpd), .accAOvf(accAOvf), .accASat(accASat),
    .accBUpd(accBUpd), .accBOvf(accBOvf), .accBSat(accBSat),
    .doActive(doActive), .repActive(repActive), .loopDepth(loopDepth), .earlyExit(earlyExit),
    .nestingDisable(nestingDisable), .priLoad(priLoad), .priIn(priIn),
    .cpuPriority(cpuPriority), .userIrqOff(userIrqOff),
    .mulUnsigned(cfg[7]), .mulInteger(cfg[6]), .accAClipEn(cfg[5]), .accBClipEn(cfg[4]),
    .memWrClipEn(cfg[3]), .superClip(cfg[2]), .progWindowEn(cfg[1]), .roundBiased(cfg[0])
  );

  // Free-running 20 MHz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expectation helpers
  function automatic logic [15:0] sx();
    logic [15:0] s;
    s = stExp;
    s[B_WAB] = s[B_WA] | s[B_WB];
    s[B_CAB] = s[B_CA] | s[B_CB];
    s[B_LP] = doActive;
    s[B_RP] = repActive;
    return s;
  endfunction

  function automatic logic [7:0] cfgx(logic [15:0] c);
    return {c[C_UNS], c[C_IF], c[C_CLA], c[C_CLB], c[C_CLM], c[C_CLW], c[C_PWN], c[C_RBS]};
  endfunction

  // Returns {nc, n, sw, z, c, result}; logic ops keep carry and digit carry
  function automatic logic [20:0] exp_alu(csc_aluop_t op, logic by, logic [15:0] a, logic [15:0] b,
                                          logic [15:0] s);
    logic [16:0] r;
    logic [15:0] m;
    logic        hc, c, nc, sw;
    int          t;
    m = by ? 16'h00FF : 16'hFFFF;
    t = by ? 7 : 15;
    a = a & m;
    b = b & m;
    c = s[B_C];
    nc = s[B_NC];
    sw = 1'b0;
    hc = 1'b0;
    case (op)
      OP_ADD: begin
        r = a + b;
        hc = by ? ((a[3:0] + b[3:0]) > 15) : ((a[7:0] + b[7:0]) > 255);
      end
      OP_SUB: begin
        r = a + (~b & m) + 17'h00001;
        hc = by ? (a[3:0] >= b[3:0]) : (a[7:0] >= b[7:0]);
      end
      OP_AND: r = {1'b0, a & b};
      OP_OR:  r = {1'b0, a | b};
      OP_XOR: r = {1'b0, a ^ b};
      // Shifts carry out the bit that falls off
      OP_SHL: begin
        r = {a, 1'b0};
        c = a[t];
      end
      OP_SHR: begin
        r = {1'b0, a >> 1};
        c = a[0];
      end
      default: begin
        r = {1'b0, a >> 1};
        r[t] = a[t];
        c = a[0];
      end
    endcase
    if (op == OP_ADD || op == OP_SUB) begin
      c = by ? r[8] : r[16];
      nc = hc;
      sw = (a[t] == (b[t] ^ (op == OP_SUB))) && (r[t] != a[t]);
    end
    return {nc, r[t], sw, (r[15:0] & m) == 16'h0000, c, r[15:0] & m};
  endfunction

  function automatic logic [31:0] exp_mul(csc_mulmode_t md, logic [15:0] a, logic [15:0] b, logic [15:0] ctl);
    logic signed [33:0] p;
    logic [16:0] x, y;
    x = {a[15], a};
    y = {b[15], b};
    case (md)
      MUL_SS:  ;
      MUL_UU:  begin x[16] = 1'b0; y[16] = 1'b0; end
      MUL_SL5: y = {12'h000, b[4:0]};
      MUL_UL5: begin x[16] = 1'b0; y = {12'h000, b[4:0]}; end
      MUL_UXS: x[16] = 1'b0;
      MUL_U8:  begin x = {9'h000, a[7:0]}; y = {9'h000, b[7:0]}; end
      default: begin
        x[16] = x[16] & ~ctl[C_UNS];
        y[16] = y[16] & ~ctl[C_UNS];
      end
    endcase
    p = $signed(x) * $signed(y);
    if (md == MUL_DSP && !ctl[C_IF]) p = p <<< 1;
    return p[31:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Compare, report and finish
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bus and engine drivers
  // Classic cycle held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [15:0] dv);
    int n;
    n = 0;
    @(posedge clock);
    {cyc, stb, we, adr, sel, wdat} <= {1'b1, 1'b1, w, a, s, 16'h0000, dv};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk("ack", 32'h1, 32'h0);
    rd = datO;
    {cyc, stb, we} <= 3'b000;
    @(posedge clock);
    lastExit = earlyExit;
  endtask

  task automatic rd16(input logic [3:0] a, input logic [15:0] e, input string nm);
    wb(1'b0, a, 4'h3, 16'h0000);
    chk(nm, 32'(e), rd);
  endtask

  task automatic alu(input csc_aluop_t op, input logic by, input logic [15:0] a, input logic [15:0] b);
    logic [20:0] x;
    @(posedge clock);
    aluGo <= 1'b1;
    aluOp <= op;
    {aluByte, aluA, aluB} <= {by, a, b};
    @(posedge clock);
    aluGo <= 1'b0;
    @(posedge clock);
    x = exp_alu(op, by, a, b, stExp);
    chk("aluDone", 32'h1, 32'(aluDone));
    chk("aluResult", 32'(x[15:0]), 32'(aluResult));
    {stExp[B_NC], stExp[B_N], stExp[B_SW], stExp[B_Z], stExp[B_C]} = x[20:16];
    rd16(ADR_STATUS, sx(), "alu flags");
  endtask

  task automatic mul(input csc_mulmode_t md, input logic [15:0] a, input logic [15:0] b);
    @(posedge clock);
    mulGo <= 1'b1;
    mulMode <= md;
    {mulA, mulB} <= {a, b};
    @(posedge clock);
    mulGo <= 1'b0;
    @(posedge clock);
    chk("mulDone", 32'h1, 32'(mulDone));
    chk("mulProduct", exp_mul(md, a, b, ctlExp), mulProduct);
  endtask

  // Accumulator pass or saturation pulse, levels as given
  task automatic evt(input logic [5:0] v);
    @(posedge clock);
    {accAUpd, accAOvf, accASat, accBUpd, accBOvf, accBSat} <= v;
    @(posedge clock);
    {accAUpd, accASat, accBUpd, accBSat} <= 4'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog; the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    chk("watchdog", 32'h0, 32'h1);
    test_done();
  end

  // Main sequence
  initial begin
    {cyc, stb, we, adr, sel, wdat, aluGo, aluByte, aluA, aluB} = '0;
    {mulGo, mulA, mulB, accAUpd, accAOvf, accASat, accBUpd, accBOvf, accBSat} = '0;
    {doActive, repActive, loopDepth, nestingDisable, priLoad, priIn} = '0;
    aluOp = OP_ADD;
    mulMode = MUL_SS;
    rst = 1'b1;
    void'($urandom(75102));
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    stExp = 16'h0000;
    ctlExp = CTL_RST;
    rd16(ADR_STATUS, sx(), "status reset");
    rd16(ADR_CONTROL, ctlExp, "control reset");
    chk("config reset", 32'(cfgx(ctlExp)), 32'(cfg));
    rd16(4'h8, 16'h0000, "unmapped read");
    // Control word: corners then random, with a signed/unsigned DSP multiply each time
    for (int i = 0; i < 14; i++) begin
      d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
      loopDepth <= 3'($urandom);
      wb(1'b1, ADR_CONTROL, 4'h3, d);
      chk("earlyExit", 32'(d[C_EXIT]), 32'(lastExit));
      ctlExp = (d & CTL_WMASK) | (ctlExp & 16'h0008) | {5'h00, loopDepth, 8'h00};
      rd16(ADR_CONTROL, ctlExp, "control");
      chk("config", 32'(cfgx(ctlExp)), 32'(cfg));
      mul(MUL_DSP, 16'($urandom), (i == 0) ? 16'h8000 : 16'($urandom));
    end
    wb(1'b1, 4'hC, 4'h3, 16'hFFFF);
    rd16(ADR_CONTROL, ctlExp, "unmapped write");
    // Every multiplier mode except DSP, extreme operands first
    for (int m = 0; m < 6; m++) begin
      mul(csc_mulmode_t'(m), 16'h8000, 16'hFFFF);
      repeat (3) mul(csc_mulmode_t'(m), 16'($urandom), 16'($urandom));
    end
    // Status writes, loop bits and priority lock
    doActive <= 1'b1;
    repActive <= 1'b1;
    wb(1'b1, ADR_STATUS, 4'h3, 16'hFFFF);
    stExp = 16'h01EF;
    rd16(ADR_STATUS, sx(), "status all ones");
    chk("priority", 32'h7, 32'(cpuPriority));
    chk("userIrqOff", 32'h1, 32'(userIrqOff));
    nestingDisable <= 1'b1;
    wb(1'b1, ADR_STATUS, 4'h1, 16'h0040);
    stExp = 16'h01E0;
    rd16(ADR_STATUS, sx(), "locked level");
    nestingDisable <= 1'b0;
    doActive <= 1'b0;
    wb(1'b1, ADR_STATUS, 4'h1, 16'h0060);
    stExp = 16'h0160;
    rd16(ADR_STATUS, sx(), "level three");
    chk("userIrqOff low", 32'h0, 32'(userIrqOff));
    // Controller loads level 10; software may clear the top bit but not set it
    @(posedge clock);
    {priLoad, priIn} <= 5'h1A;
    @(posedge clock);
    priLoad <= 1'b0;
    @(posedge clock);
    chk("priority load", 32'hA, 32'(cpuPriority));
    chk("userIrqOff top", 32'h1, 32'(userIrqOff));
    stExp[7:5] = 3'h2;
    ctlExp[C_PRI3] = 1'b1;
    rd16(ADR_CONTROL, ctlExp, "top bit set");
    rd16(ADR_STATUS, sx(), "low bits");
    ctlExp[C_PRI3] = 1'b0;
    wb(1'b1, ADR_CONTROL, 4'h1, ctlExp);
    rd16(ADR_CONTROL, ctlExp, "top bit clear");
    wb(1'b1, ADR_CONTROL, 4'h1, ctlExp | 16'h0008);
    rd16(ADR_CONTROL, ctlExp, "top bit stays");
    chk("priority low", 32'h2, 32'(cpuPriority));
    // Accumulator overflow follows each pass, saturation is sticky
    evt(6'b110110);
    stExp[15:14] = 2'b11;
    rd16(ADR_STATUS, sx(), "both wrap");
    evt(6'b100000);
    stExp[15] = 1'b0;
    rd16(ADR_STATUS, sx(), "a wrap gone");
    evt(6'b000100);
    stExp[14] = 1'b0;
    rd16(ADR_STATUS, sx(), "no wrap");
    evt(6'b001001);
    stExp[13:12] = 2'b11;
    rd16(ADR_STATUS, sx(), "both clipped");
    wb(1'b1, ADR_STATUS, 4'h2, 16'hEC00 | (stExp & 16'h0100));
    stExp[12] = 1'b0;
    rd16(ADR_STATUS, sx(), "b clip cleared");
    evt(6'b000001);
    wb(1'b1, ADR_STATUS, 4'h2, 16'hF000 | (stExp & 16'h0100));
    stExp[13] = 1'b0;
    rd16(ADR_STATUS, sx(), "any clip cleared");
    wb(1'b1, ADR_STATUS, 4'h2, 16'hFE00 | (stExp & 16'h0100));
    rd16(ADR_STATUS, sx(), "no set by write");
    // Arithmetic corners, then random operations
    alu(OP_ADD, 1'b0, 16'h7FFF, 16'h0001);
    alu(OP_ADD, 1'b0, 16'hFFFF, 16'h0001);
    alu(OP_ADD, 1'b1, 16'h120F, 16'h3401);
    alu(OP_ADD, 1'b1, 16'h0080, 16'h0080);
    alu(OP_SUB, 1'b0, 16'h0000, 16'h0001);
    alu(OP_SUB, 1'b1, 16'hAB05, 16'h0005);
    alu(OP_AND, 1'b0, 16'h00F0, 16'h0F0F);
    alu(OP_SHL, 1'b1, 16'h00C1, 16'h0000);
    alu(OP_ASR, 1'b0, 16'h8001, 16'h0000);
    alu(OP_SHR, 1'b1, 16'h0001, 16'h0000);
    for (int i = 0; i < 40; i++) begin
      alu(csc_aluop_t'($urandom_range(7, 0)), 1'($urandom), 16'($urandom), 16'($urandom));
    end
    test_done();
  end
endmodule
